/* File: dmac_top.sv */
/*
 * Address and count bookkeeping of a four-channel DMA controller with an
 * APB register slave. Each channel keeps a read pointer, a write pointer,
 * a frame/element counter and a small control word; two shared reload
 * words and two shared step words are picked per channel.
 * Assumes rd_done and wr_done come from logic on pclk as one-cycle pulses,
 * one per element, and that software programs a channel while it is idle.
 */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dmac_map.svh"

module dmac_top #(
	parameter int NCH = 4
) (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           ce,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output      logic [31:0]    prdata,
	output      logic           pready,
	output      logic           pslverr,
	input  wire logic [NCH-1:0] rd_done,
	input  wire logic [NCH-1:0] wr_done,
	output      logic [NCH-1:0] frame_done,
	output      logic [NCH-1:0] block_done
);
	// ----------------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------------
	logic [31:0]                rptr_q   [NCH];
	logic [31:0]                wptr_q   [NCH];
	logic [`DMAC_CTL_WIDTH-1:0] ctrl_q   [NCH];
	logic [31:0]                cnt      [NCH];
	logic [31:0]                reload_q [2];
	logic [31:0]                step_q   [2];

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------------
	logic        setup;
	logic        wr_acc;
	logic        is_ch;
	logic [1:0]  ch;
	logic [3:0]  sub;
	logic        hit;
	logic [31:0] rd_val;

	assign setup  = psel & ~penable & ~pready_q;
	assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign ch     = paddr[5:4];
	assign sub    = paddr[3:0];
	assign is_ch  = (paddr[7:6] == 2'b00) && (32'(ch) < NCH);

	always_comb begin
		hit    = 1'b1;
		rd_val = `DMAC_RESET_WORD;
		if (is_ch) begin
			unique case (sub)
				`DMAC_OFF_CTRL: rd_val = 32'(ctrl_q[ch]);
				`DMAC_OFF_RPTR: rd_val = rptr_q[ch];
				`DMAC_OFF_WPTR: rd_val = wptr_q[ch];
				`DMAC_OFF_CNT:  rd_val = cnt[ch];
				default:        hit    = 1'b0;
			endcase
		end else begin
			unique case (paddr)
				`DMAC_OFF_RELOAD_A: rd_val = reload_q[0];
				`DMAC_OFF_RELOAD_B: rd_val = reload_q[1];
				`DMAC_OFF_STEP_A:   rd_val = step_q[0];
				`DMAC_OFF_STEP_B:   rd_val = step_q[1];
				default:            hit    = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------------
	// Every transfer with ce high completes without a wait state; read data is captured in
	// the setup cycle, so a pointer that moves during the access cycle is not seen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `DMAC_RESET_WORD;
		end else if (ce) begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			if (setup) begin
				prdata_q <= (hit && !pwrite) ? rd_val : `DMAC_RESET_WORD;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Shared reload and step words
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_q[0] <= `DMAC_RESET_WORD;
			reload_q[1] <= `DMAC_RESET_WORD;
			step_q[0]   <= `DMAC_RESET_WORD;
			step_q[1]   <= `DMAC_RESET_WORD;
		end else if (ce && wr_acc && !is_ch) begin
			unique case (paddr)
				`DMAC_OFF_RELOAD_A: reload_q[0] <= pwdata;
				`DMAC_OFF_RELOAD_B: reload_q[1] <= pwdata;
				`DMAC_OFF_STEP_A:   step_q[0]   <= pwdata;
				`DMAC_OFF_STEP_B:   step_q[1]   <= pwdata;
				default:            step_q[0]   <= step_q[0];
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------------
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic        sel;
		logic [31:0] reload;
		logic [31:0] step;
		logic        rd_last;
		logic        wr_last;
		logic [31:0] rnext;
		logic [31:0] wnext;

		assign sel    = wr_acc && is_ch && (32'(ch) == i);
		assign reload = reload_q[ctrl_q[i][`DMAC_CTL_RELOAD_SEL]];
		assign step   = step_q[ctrl_q[i][`DMAC_CTL_STEP_SEL]];

		dmac_chan #(
			.CW (16)
		) u_chan (
			.pclk         (pclk),
			.presetn      (presetn),
			.ce           (ce),
			.cnt_we       (sel && sub == `DMAC_OFF_CNT),
			.wdata        (pwdata),
			.reload       (reload),
			.rd_done      (rd_done[i]),
			.wr_done      (wr_done[i]),
			.counter      (cnt[i]),
			.rd_last      (rd_last),
			.wr_last      (wr_last),
			.frame_done_q (frame_done[i]),
			.block_done_q (block_done[i])
		);

		dmac_step u_rstep (
			.ptr       (rptr_q[i]),
			.dir       (dmac_pkg::dmac_dir_type'(ctrl_q[i][`DMAC_CTL_RDIR_LSB +: 2])),
			.step_word (step),
			.last      (rd_last),
			.next_ptr  (rnext)
		);

		dmac_step u_wstep (
			.ptr       (wptr_q[i]),
			.dir       (dmac_pkg::dmac_dir_type'(ctrl_q[i][`DMAC_CTL_WDIR_LSB +: 2])),
			.step_word (step),
			.last      (wr_last),
			.next_ptr  (wnext)
		);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ctrl_q[i] <= `DMAC_RESET_CTRL;
			end else if (ce && sel && sub == `DMAC_OFF_CTRL) begin
				ctrl_q[i] <= pwdata[`DMAC_CTL_WIDTH-1:0];
			end
		end

		// A software write wins over a completion in the same cycle.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rptr_q[i] <= `DMAC_RESET_WORD;
			end else if (ce) begin
				if (sel && sub == `DMAC_OFF_RPTR) begin
					rptr_q[i] <= pwdata;
				end else if (rd_done[i]) begin
					rptr_q[i] <= rnext;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				wptr_q[i] <= `DMAC_RESET_WORD;
			end else if (ce) begin
				if (sel && sub == `DMAC_OFF_WPTR) begin
					wptr_q[i] <= pwdata;
				end else if (wr_done[i]) begin
					wptr_q[i] <= wnext;
				end
			end
		end
	end

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic sw0_r;
	logic sw0_w;
	logic idx0_r;
	logic idx0_w;
	assign sw0_r  = g_ch[0].sel && sub == `DMAC_OFF_RPTR;
	assign sw0_w  = g_ch[0].sel && sub == `DMAC_OFF_WPTR;
	assign idx0_r = ctrl_q[0][`DMAC_CTL_RDIR_LSB +: 2] == 2'b11;
	assign idx0_w = ctrl_q[0][`DMAC_CTL_WDIR_LSB +: 2] == 2'b11;

	property p_wptr_write;
		ce && sw0_w |=> wptr_q[0] == $past(pwdata)
			##1 $stable(wptr_q[0]) || $past(sw0_w) || $past(wr_done[0]) || !$past(ce);
	endproperty
	a_wptr_write: assert property (p_wptr_write) else $error("write pointer store lost");

	property p_unmapped;
		ce && setup && !hit |=> pready && pslverr && prdata == `DMAC_RESET_WORD;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

	property p_answer;
		ce && setup |=> pready ##1 !pready || !$past(ce);
	endproperty
	a_answer: assert property (p_answer) else $error("apb answer timing wrong");

	property p_elem_step;
		ce && !sw0_r && rd_done[0] && idx0_r && !g_ch[0].rd_last
			|=> rptr_q[0] == $past(rptr_q[0]) + {{16{$past(g_ch[0].step[15])}},
				$past(g_ch[0].step[15:0])};
	endproperty
	a_elem_step: assert property (p_elem_step) else $error("element step wrong");

	property p_frame_step;
		ce && !sw0_r && rd_done[0] && idx0_r && g_ch[0].rd_last
			|=> rptr_q[0] == $past(rptr_q[0]) + {{16{$past(g_ch[0].step[31])}},
				$past(g_ch[0].step[31:16])};
	endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame step wrong");

	property p_rptr_hold;
		ce && !sw0_r && !rd_done[0] && wr_done[0] |=> $stable(rptr_q[0]);
	endproperty
	a_rptr_hold: assert property (p_rptr_hold) else $error("read pointer moved on write");

	property p_rptr_rd;
		ce && sw0_r |=> rptr_q[0] == $past(pwdata);
	endproperty
	a_rptr_rd: assert property (p_rptr_rd) else $error("read pointer store lost");

	property p_frame_flag;
		ce && rd_done[0] && g_ch[0].rd_last && !(g_ch[0].sel && sub == `DMAC_OFF_CNT)
			|=> frame_done[0] ##1 !frame_done[0] || $past(rd_done[0]) || !$past(ce);
	endproperty
	a_frame_flag: assert property (p_frame_flag) else $error("frame flag wrong");

	// The write side has no counter of its own on the bus, so its step is
	// checked here against the shared step word rather than a register read.
	property p_wptr_step;
		ce && !sw0_w && wr_done[0] && idx0_w
			|=> wptr_q[0] - $past(wptr_q[0]) == ($past(g_ch[0].wr_last) ?
				{{16{$past(g_ch[0].step[31])}}, $past(g_ch[0].step[31:16])} :
				{{16{$past(g_ch[0].step[15])}}, $past(g_ch[0].step[15:0])});
	endproperty
	a_wptr_step: assert property (p_wptr_step) else $error("write pointer step wrong");

	property p_block_flag;
		ce && rd_done[0] && g_ch[0].rd_last && cnt[0][31:16] <= 16'h0001
			&& !(g_ch[0].sel && sub == `DMAC_OFF_CNT) |=> block_done[0];
	endproperty
	a_block_flag: assert property (p_block_flag) else $error("block flag missed");

	c_write: cover property (ce && wr_acc && hit);
	c_read: cover property (ce && setup && !pwrite && hit);
	c_block: cover property (block_done[0]);
endmodule

/* File: dmac_map.svh */
/*
 * Register offsets, control field positions and reset values of the DMA
 * count and index block. Included by every file that decodes or resets them.
 */
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// ----------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------
`define DMAC_CH_STRIDE      8'h10
`define DMAC_OFF_CTRL       4'h0
`define DMAC_OFF_RPTR       4'h4
`define DMAC_OFF_WPTR       4'h8
`define DMAC_OFF_CNT        4'hc
`define DMAC_OFF_RELOAD_A   8'h40
`define DMAC_OFF_RELOAD_B   8'h44
`define DMAC_OFF_STEP_A     8'h48
`define DMAC_OFF_STEP_B     8'h4c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DMAC_CTL_RELOAD_SEL 0
`define DMAC_CTL_STEP_SEL   1
`define DMAC_CTL_RDIR_LSB   2
`define DMAC_CTL_WDIR_LSB   4
`define DMAC_CTL_WIDTH      6
`define DMAC_HI_LSB         16

// ----------------------------------------------------------------------
// Reset values and fixed amounts
// ----------------------------------------------------------------------
`define DMAC_RESET_WORD     32'h0000_0000
`define DMAC_RESET_HALF     16'h0000
`define DMAC_RESET_CTRL     6'h00
`define DMAC_ELEM_BYTES     32'h0000_0004

`endif

/* File: dmac_pkg.sv */
/*
 * Types shared by the DMA count and index block.
 * Assumes nothing of its surroundings.
 */
package dmac_pkg;

	// Pointer direction field: hold, step by one element, or use the index.
	typedef enum logic [1:0] {
		DMAC_DIR_HOLD  = 2'b00,
		DMAC_DIR_INC   = 2'b01,
		DMAC_DIR_DEC   = 2'b10,
		DMAC_DIR_INDEX = 2'b11
	} dmac_dir_type;

endpackage

/* File: dmac_step.sv */
/*
 * Next-pointer arithmetic for one read or write pointer.
 * Assumes the caller registers the result and gives a same-clock advance.
 */
`timescale 1ns/1ps
`include "dmac_map.svh"

module dmac_step (
	input  wire logic [31:0]           ptr,
	input  wire dmac_pkg::dmac_dir_type dir,
	input  wire logic [31:0]           step_word,
	input  wire logic                  last,
	output      logic [31:0]           next_ptr
);
	logic [15:0] idx;

	always_comb begin
		idx = last ? step_word[31:16] : step_word[15:0];
		unique case (dir)
			dmac_pkg::DMAC_DIR_HOLD:  next_ptr = ptr;
			dmac_pkg::DMAC_DIR_INC:   next_ptr = ptr + `DMAC_ELEM_BYTES;
			dmac_pkg::DMAC_DIR_DEC:   next_ptr = ptr - `DMAC_ELEM_BYTES;
			dmac_pkg::DMAC_DIR_INDEX: next_ptr = ptr + {{16{idx[15]}}, idx};
		endcase
	end
endmodule

/* File: dmac_chan.sv */
/*
 * Frame and element counters of one channel, plus a separate write-side
 * position so that both pointers find their own last transfer.
 * Assumes read and write completions are same-clock one-cycle pulses.
 */
`timescale 1ns/1ps
`include "dmac_map.svh"

module dmac_chan #(
	parameter int CW = 16
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic          cnt_we,
	input  wire logic [31:0]   wdata,
	input  wire logic [31:0]   reload,
	input  wire logic          rd_done,
	input  wire logic          wr_done,
	output      logic [31:0]   counter,
	output      logic          rd_last,
	output      logic          wr_last,
	output      logic          frame_done_q,
	output      logic          block_done_q
);
	logic [CW-1:0] frame_q;
	logic [CW-1:0] elem_q;
	logic [CW-1:0] wr_left_q;
	logic [CW-1:0] wr_cur;
	logic          last_frame;

	assign counter    = {frame_q, elem_q};
	// A zero element count is not defined; it is treated like one.
	assign rd_last    = (elem_q <= 16'h0001);
	// A frame count of zero ends the block just as one does.
	assign last_frame = (frame_q <= 16'h0001);
	// Write side restarts each frame from the reload length.
	assign wr_cur     = (wr_left_q == 16'h0000) ? reload[CW-1:0] : wr_left_q;
	assign wr_last    = (wr_cur <= 16'h0001);

	// ----------------------------------------------------------------------
	// Read-side counters
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_q <= `DMAC_RESET_HALF;
			elem_q  <= `DMAC_RESET_HALF;
		end else if (ce) begin
			if (cnt_we) begin
				frame_q <= wdata[31:16];
				elem_q  <= wdata[15:0];
			end else if (rd_done) begin
				if (rd_last) begin
					elem_q <= reload[CW-1:0];
					if (last_frame) begin
						frame_q <= reload[31:16];
					end else begin
						frame_q <= frame_q - 16'h0001;
					end
				end else begin
					elem_q <= elem_q - 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------------------------------------
	// Write-side position and completion flags
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_left_q <= `DMAC_RESET_HALF;
		end else if (ce) begin
			if (cnt_we) begin
				wr_left_q <= `DMAC_RESET_HALF;
			end else if (wr_done) begin
				wr_left_q <= wr_last ? `DMAC_RESET_HALF : wr_cur - 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_done_q <= 1'b0;
			block_done_q <= 1'b0;
		end else if (ce) begin
			frame_done_q <= rd_done & rd_last & ~cnt_we;
			block_done_q <= rd_done & rd_last & last_frame & ~cnt_we;
		end
	end

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_frame_dec;
		ce && !cnt_we && rd_done && rd_last && !last_frame |=> frame_q == $past(frame_q) - 16'h0001;
	endproperty
	a_frame_dec: assert property (p_frame_dec) else $error("frame count did not step down");

	property p_frame_reload;
		ce && !cnt_we && rd_done && rd_last && last_frame
			|=> frame_q == $past(reload[31:16]) && block_done_q;
	endproperty
	a_frame_reload: assert property (p_frame_reload) else $error("frame reload missed");

	property p_elem_dec;
		ce && !cnt_we && rd_done && !rd_last |=> elem_q == $past(elem_q) - 16'h0001;
	endproperty
	a_elem_dec: assert property (p_elem_dec) else $error("element count did not step down");

	property p_elem_reload;
		ce && !cnt_we && rd_done && rd_last |=> elem_q == $past(reload[15:0])
			##1 !frame_done_q || $past(rd_done) || !$past(ce);
	endproperty
	a_elem_reload: assert property (p_elem_reload) else $error("element reload missed");

	property p_wr_indep;
		ce && !cnt_we && wr_done && !rd_done |=> $stable(elem_q) && $stable(frame_q);
	endproperty
	a_wr_indep: assert property (p_wr_indep) else $error("write moved read counters");

	c_block: cover property (ce && rd_done && rd_last && last_frame && !cnt_we);
endmodule

/* File: test_dma_channel_count_index_update.sv */
/*
 * Self-checking testbench of the DMA count and index block (dmac_top).
 * Drives the APB register bus and the per-channel completion pulses
 * itself; waits on pready for each transfer and expects registered flags.
 */
`timescale 1ns/1ps
`include "dmac_map.svh"

module test_dma_channel_count_index_update;

	localparam int NCH = 4;

	logic           pclk;
	logic           presetn;
	logic           ce;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [7:0]     paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic [NCH-1:0] rd_done;
	logic [NCH-1:0] wr_done;
	logic [NCH-1:0] frame_done;
	logic [NCH-1:0] block_done;
	logic [31:0]    rdat;
	logic           rerr;
	logic           fd_seen;
	logic           bd_seen;
	logic [31:0]    sh [4];
	int             errors = 0;
	int             checks = 0;
	int             cycles = 0;

	dmac_top #(.NCH(NCH)) dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rd_done(rd_done), .wr_done(wr_done),
		.frame_done(frame_done), .block_done(block_done)
	);

	// ----------------------------------------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// The whole run needs a few hundred cycles; this ceiling only cuts a hang.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task results;
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ----------------------------------------------------------------------
	// Bus and completion helpers
	// ----------------------------------------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		check({31'h0, rerr}, 32'h0);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		apb(1'b0, a, 32'h0);
		check(rdat, exp);
		check({31'h0, rerr}, {31'h0, eerr});
	endtask

	// Flags are registered, so they are looked at just after the taking edge.
	task pulse(input int ch, input logic r, input logic w);
		@(posedge pclk);
		rd_done[ch] <= r;
		wr_done[ch] <= w;
		@(posedge pclk);
		rd_done[ch] <= 1'b0;
		wr_done[ch] <= 1'b0;
		#1;
		fd_seen = frame_done[ch];
		bd_seen = block_done[ch];
	endtask

	function logic [7:0] base(input int ch);
		return 8'(ch * 16);
	endfunction

	function logic [31:0] sx(input logic [15:0] h);
		return {{16{h[15]}}, h};
	endfunction

	function logic [31:0] ctl(input dmac_pkg::dmac_dir_type wd, input dmac_pkg::dmac_dir_type rdr,
			input logic ss, input logic rs);
		return {26'h0, wd, rdr, ss, rs};
	endfunction

	// Reference model of the read side, worked out from the counting rules.
	task run_rd(input int ch, input int n, input logic [31:0] cnt0, input logic [31:0] p0,
			input logic [31:0] rel, input logic [31:0] stp);
		logic [15:0] e;
		logic [15:0] f;
		logic [31:0] p;
		logic        fd;
		logic        bd;
		e = cnt0[15:0];
		f = cnt0[31:16];
		p = p0;
		for (int k = 0; k < n; k++) begin
			fd = 1'b0;
			bd = 1'b0;
			pulse(ch, 1'b1, 1'b0);
			if (e <= 16'h0001) begin
				e = rel[15:0];
				fd = 1'b1;
				p = p + sx(stp[31:16]);
				if (f <= 16'h0001) begin
					f = rel[31:16];
					bd = 1'b1;
				end else begin
					f = f - 16'h0001;
				end
			end else begin
				e = e - 16'h0001;
				p = p + sx(stp[15:0]);
			end
			check({31'h0, fd_seen}, {31'h0, fd});
			check({31'h0, bd_seen}, {31'h0, bd});
			rd_chk(base(ch) + `DMAC_OFF_CNT, {f, e}, 1'b0);
			rd_chk(base(ch) + `DMAC_OFF_RPTR, p, 1'b0);
		end
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		ce      = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		rd_done = '0;
		wr_done = '0;
		sh = '{32'h0007_0003, 32'h0005_0002, 32'hfff0_0008, 32'h0020_fffc};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int c = 0; c < NCH; c++)
			for (int o = 0; o < 16; o += 4)
				rd_chk(base(c) + 8'(o), 32'h0, 1'b0);
		for (int i = 0; i < 4; i++)
			rd_chk(`DMAC_OFF_RELOAD_A + 8'(4 * i), 32'h0, 1'b0);
		apb(1'b1, 8'h50, 32'hffff_ffff);
		check({31'h0, rerr}, 32'h1);
		rd_chk(8'h50, 32'h0, 1'b1);
		rd_chk(8'h06, 32'h0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(`DMAC_OFF_RELOAD_A + 8'(4 * i), sh[i]);
			rd_chk(`DMAC_OFF_RELOAD_A + 8'(4 * i), sh[i], 1'b0);
		end
		// Two frames of three elements, both pointers stepped by the index.
		wr(base(0) + `DMAC_OFF_CTRL, ctl(dmac_pkg::DMAC_DIR_INDEX, dmac_pkg::DMAC_DIR_INDEX, 1'b0, 1'b0));
		wr(base(0) + `DMAC_OFF_RPTR, 32'h0000_1000);
		wr(base(0) + `DMAC_OFF_WPTR, 32'h0000_2000);
		wr(base(0) + `DMAC_OFF_CNT, 32'h0002_0003);
		run_rd(0, 6, 32'h0002_0003, 32'h0000_1000, sh[0], sh[2]);
		pulse(0, 1'b0, 1'b1);
		rd_chk(base(0) + `DMAC_OFF_WPTR, 32'h0000_2008, 1'b0);
		pulse(0, 1'b0, 1'b1);
		rd_chk(base(0) + `DMAC_OFF_WPTR, 32'h0000_2010, 1'b0);
		pulse(0, 1'b0, 1'b1);
		rd_chk(base(0) + `DMAC_OFF_WPTR, 32'h0000_2000, 1'b0);
		rd_chk(base(0) + `DMAC_OFF_CNT, 32'h0007_0003, 1'b0);
		rd_chk(base(0) + `DMAC_OFF_RPTR, 32'h0000_1000, 1'b0);
		// A frame count of zero runs one frame; second reload and step words.
		wr(base(1) + `DMAC_OFF_CTRL, ctl(dmac_pkg::DMAC_DIR_HOLD, dmac_pkg::DMAC_DIR_INDEX, 1'b1, 1'b1));
		wr(base(1) + `DMAC_OFF_RPTR, 32'h0000_3000);
		wr(base(1) + `DMAC_OFF_WPTR, 32'h0000_4000);
		wr(base(1) + `DMAC_OFF_CNT, 32'h0000_0002);
		run_rd(1, 4, 32'h0000_0002, 32'h0000_3000, sh[1], sh[3]);
		pulse(1, 1'b0, 1'b1);
		rd_chk(base(1) + `DMAC_OFF_WPTR, 32'h0000_4000, 1'b0);
		// Plain increment and decrement, read and write in the same cycle.
		wr(base(2) + `DMAC_OFF_CTRL, ctl(dmac_pkg::DMAC_DIR_DEC, dmac_pkg::DMAC_DIR_INC, 1'b0, 1'b0));
		rd_chk(base(2) + `DMAC_OFF_CTRL, 32'h0000_0024, 1'b0);
		wr(base(2) + `DMAC_OFF_RPTR, 32'h0000_0100);
		wr(base(2) + `DMAC_OFF_WPTR, 32'h0000_0200);
		wr(base(2) + `DMAC_OFF_CNT, 32'h0001_0004);
		pulse(2, 1'b1, 1'b1);
		pulse(2, 1'b1, 1'b1);
		rd_chk(base(2) + `DMAC_OFF_RPTR, 32'h0000_0108, 1'b0);
		rd_chk(base(2) + `DMAC_OFF_WPTR, 32'h0000_01f8, 1'b0);
		rd_chk(base(2) + `DMAC_OFF_CNT, 32'h0001_0002, 1'b0);
		// Full-scale counts; a pulse while the clock enable is low is ignored.
		wr(base(3) + `DMAC_OFF_WPTR, 32'hffff_ffff);
		rd_chk(base(3) + `DMAC_OFF_WPTR, 32'hffff_ffff, 1'b0);
		wr(base(3) + `DMAC_OFF_CNT, 32'hffff_ffff);
		rd_chk(base(3) + `DMAC_OFF_CNT, 32'hffff_ffff, 1'b0);
		pulse(3, 1'b1, 1'b0);
		rd_chk(base(3) + `DMAC_OFF_CNT, 32'hffff_fffe, 1'b0);
		@(posedge pclk);
		ce <= 1'b0;
		pulse(3, 1'b1, 1'b0);
		@(posedge pclk);
		ce <= 1'b1;
		rd_chk(base(3) + `DMAC_OFF_CNT, 32'hffff_fffe, 1'b0);
		results();
	end

endmodule
